// ===== sfr_dev.sv
module sfr_dev
   import sfr_pkg::*;
(
   // Clock and reset
   input  wire logic                     ref_clk,
   input  wire logic                     nrst,
   // Serial link
   sfr_if.dev                            lnk,
   // Configuration
   input  wire logic                     page_size_bin,
   // Storage read port
   output logic      [sfr_pkg::PAGE_W-1:0] mem_page,
   output logic      [sfr_pkg::BYTE_W-1:0] mem_byte,
   output logic                          mem_buf_sel,
   output logic                          mem_rd,
   input  wire logic [7:0]               mem_data
);
   import sfr_pkg::*;

   typedef struct packed
   {
      sfr_dev_st_t          st;
      sfr_rd_t              kind;
      logic [ADDR_W-1:0]    sh;
      logic [5:0]           cnt;
      logic [5:0]           dmy;
      logic [PAGE_W-1:0]    page;
      logic [BYTE_W-1:0]    byte_ofs;
      logic [6:0]           obuf;
      logic                 so_bit;
      logic                 oe_n;
      logic                 sck_q;
      logic                 cs_q;
   } sfr_dev_state_t;

   sfr_dev_state_t r_reg;
   sfr_dev_state_t r_next;

   logic              rise;
   logic              fall;
   logic [ADDR_W-1:0] addr_in;
   logic [7:0]        opc_in;
   logic [8:0]        last_byte;
   logic              at_last;
   logic              fetch;

   // Edge detection of the serial clock in the system clock domain
   assign rise      = lnk.sck & ~r_reg.sck_q;
   assign fall      = ~lnk.sck & r_reg.sck_q;
   assign addr_in   = {r_reg.sh[ADDR_W-2:0], lnk.si};
   assign opc_in    = addr_in[OPC_W-1:0];
   assign last_byte = page_size_bin ? LAST_BIN : LAST_WIDE;
   assign at_last   = r_reg.byte_ofs >= last_byte;
   assign fetch     = (r_reg.st == D_DATA) && fall && (r_reg.cnt[2:0] == 3'h0) && !lnk.cs_n;

   // Storage port follows the address registers
   assign mem_page    = r_reg.page;
   assign mem_byte    = r_reg.byte_ofs;
   assign mem_buf_sel = (r_reg.kind == RD_BUF);
   assign mem_rd      = fetch;
   assign lnk.so_drv  = r_reg.so_bit;
   assign lnk.so_oe_n = r_reg.oe_n;

   // Next-state logic of the whole front end
   always_comb
   begin
      r_next       = r_reg;
      r_next.sck_q = lnk.sck;
      r_next.cs_q  = lnk.cs_n;
      if (lnk.cs_n)
      begin
         // Deselect aborts everything at once
         r_next.st   = D_IDLE;
         r_next.oe_n = 1'b1;
         r_next.cnt  = 6'h00;
      end
      else
      begin
         case (r_reg.st)
            D_IDLE:
            begin
               // Only a real falling edge opens a frame
               if (r_reg.cs_q)
               begin
                  r_next.st  = D_OPC;
                  r_next.cnt = 6'h00;
               end
            end
            D_OPC:
            begin
               if (rise)
               begin
                  r_next.sh  = addr_in;
                  r_next.cnt = r_reg.cnt + 6'h01;
                  if (r_reg.cnt == 6'h07)
                  begin
                     r_next.kind = sfr_decode(opc_in);
                     r_next.dmy  = sfr_dummy_bits(opc_in);
                     r_next.cnt  = 6'h00;
                     // Unknown opcodes park until deselect
                     r_next.st = (sfr_decode(opc_in) == RD_NONE) ? D_IGNORE : D_ADDR;
                  end
               end
            end
            D_ADDR:
            begin
               if (rise)
               begin
                  r_next.sh  = addr_in;
                  r_next.cnt = r_reg.cnt + 6'h01;
                  if (r_reg.cnt == 6'h17)
                  begin
                     r_next.cnt = 6'h00;
                     if (r_reg.kind == RD_BUF)
                     begin
                        r_next.page     = '0;
                        // High bits of the buffer address are ignored
                        r_next.byte_ofs = page_size_bin ? {1'b0, addr_in[7:0]}
                                                        : addr_in[BYTE_W-1:0];
                     end
                     else if (page_size_bin)
                     begin
                        r_next.page     = addr_in[BIN_PAGE_LO +: PAGE_W];
                        r_next.byte_ofs = {1'b0, addr_in[7:0]};
                     end
                     else
                     begin
                        r_next.page     = addr_in[WIDE_PAGE_LO +: PAGE_W];
                        r_next.byte_ofs = addr_in[BYTE_W-1:0];
                     end
                     r_next.st = (r_reg.dmy == DUMMY_NONE) ? D_DATA : D_DUMMY;
                  end
               end
            end
            D_DUMMY:
            begin
               // Don't-care bits are counted and dropped
               if (rise)
               begin
                  r_next.cnt = r_reg.cnt + 6'h01;
                  if (r_reg.cnt == r_reg.dmy - 6'h01)
                  begin
                     r_next.cnt = 6'h00;
                     r_next.st  = D_DATA;
                  end
               end
            end
            D_DATA:
            begin
               if (fall)
               begin
                  r_next.oe_n = 1'b0;
                  r_next.cnt  = {3'h0, r_reg.cnt[2:0] + 3'h1};
                  if (fetch)
                  begin
                     // Whole byte taken at once, then streamed out
                     r_next.so_bit = mem_data[7];
                     r_next.obuf   = mem_data[6:0];
                     r_next.byte_ofs = at_last ? '0 : r_reg.byte_ofs + 9'h001;
                     if (at_last && r_reg.kind == RD_CONT)
                     begin
                        r_next.page = r_reg.page + 9'h001;
                     end
                     // Page read keeps its page on wrap
                     if (r_reg.kind == RD_PAGE)
                     begin
                        r_next.page = r_reg.page;
                     end
                  end
                  else
                  begin
                     r_next.so_bit = r_reg.obuf[6];
                     r_next.obuf   = {r_reg.obuf[5:0], 1'b0};
                  end
               end
            end
            D_IGNORE:
            begin
               r_next.oe_n = 1'b1;
            end
            default:
            begin
               r_next.st = D_IDLE;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         r_reg.st       <= D_IDLE;
         r_reg.kind     <= RD_NONE;
         r_reg.sh       <= '0;
         r_reg.cnt      <= 6'h00;
         r_reg.dmy      <= 6'h00;
         r_reg.page     <= '0;
         r_reg.byte_ofs <= '0;
         r_reg.obuf     <= 7'h00;
         r_reg.so_bit   <= 1'b0;
         r_reg.oe_n     <= 1'b1;
         r_reg.sck_q    <= 1'b0;
         r_reg.cs_q     <= 1'b1;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

endmodule : sfr_dev

// ===== sfr_pkg.sv
package sfr_pkg;

   // Opcodes of the read commands handled here
   localparam logic [7:0] OPC_CAR_LEGACY = 8'he8;
   localparam logic [7:0] OPC_CAR_FAST   = 8'h0b;
   localparam logic [7:0] OPC_CAR_SLOW   = 8'h03;
   localparam logic [7:0] OPC_PAGE_READ  = 8'hd2;
   localparam logic [7:0] OPC_BUF_FAST   = 8'hd4;
   localparam logic [7:0] OPC_BUF_SLOW   = 8'hd1;

   // Field widths and layout of the three address bytes
   localparam int         OPC_W        = 8;
   localparam int         ADDR_W       = 24;
   localparam int         PAGE_W       = 9;
   localparam int         BYTE_W       = 9;
   localparam int         TX_W         = 64;
   localparam int         CNT_W        = 20;
   localparam int         WIDE_PAGE_LO = 9;
   localparam int         BIN_PAGE_LO  = 8;
   localparam logic [8:0] LAST_WIDE    = 9'h107;
   localparam logic [8:0] LAST_BIN     = 9'h0ff;

   // Don't-care bit counts after the address
   localparam logic [5:0] DUMMY_NONE  = 6'h00;
   localparam logic [5:0] DUMMY_SHORT = 6'h08;
   localparam logic [5:0] DUMMY_LONG  = 6'h20;

   // Serial clock limits (MHz) and the host divider built from the 10 MHz clock
   localparam int REF_CLK_MHZ           = 10;
   localparam int FAST_READ_CLOCK_LIMIT = 66;
   localparam int SLOW_READ_CLOCK_LIMIT = 33;
   localparam int SCK_HALF_MIN          = 2;
   localparam int SCK_HALF_CYC          = (REF_CLK_MHZ / (2 * SLOW_READ_CLOCK_LIMIT)) > SCK_HALF_MIN
                                        ? (REF_CLK_MHZ / (2 * SLOW_READ_CLOCK_LIMIT)) : SCK_HALF_MIN;

   // Read kinds, one-hot
   typedef enum logic [3:0]
   {
      RD_NONE = 4'h1,
      RD_CONT = 4'h2,
      RD_PAGE = 4'h4,
      RD_BUF  = 4'h8
   } sfr_rd_t;

   // Device front-end states
   typedef enum logic [5:0]
   {
      D_IDLE   = 6'h01,
      D_OPC    = 6'h02,
      D_ADDR   = 6'h04,
      D_DUMMY  = 6'h08,
      D_DATA   = 6'h10,
      D_IGNORE = 6'h20
   } sfr_dev_st_t;

   // Host sequencer states
   typedef enum logic [5:0]
   {
      H_IDLE  = 6'h01,
      H_LEAD  = 6'h02,
      H_LOW   = 6'h04,
      H_HIGH  = 6'h08,
      H_TRAIL = 6'h10,
      H_GAP   = 6'h20
   } sfr_host_st_t;

   // Opcode to read kind
   function automatic sfr_rd_t sfr_decode(input logic [7:0] opc);
      sfr_rd_t k;
      case (opc)
         OPC_CAR_LEGACY, OPC_CAR_FAST, OPC_CAR_SLOW: k = RD_CONT;
         OPC_PAGE_READ:                              k = RD_PAGE;
         OPC_BUF_FAST, OPC_BUF_SLOW:                 k = RD_BUF;
         default:                                    k = RD_NONE;
      endcase
      return k;
   endfunction : sfr_decode

   // Don't-care bits between address and data
   function automatic logic [5:0] sfr_dummy_bits(input logic [7:0] opc);
      logic [5:0] d;
      case (opc)
         OPC_CAR_LEGACY, OPC_PAGE_READ:           d = DUMMY_LONG;
         OPC_CAR_FAST, OPC_BUF_FAST, OPC_BUF_SLOW: d = DUMMY_SHORT;
         default:                                 d = DUMMY_NONE;
      endcase
      return d;
   endfunction : sfr_dummy_bits

endpackage : sfr_pkg

// ===== sfr_if.sv
interface sfr_if;
   logic cs_n;
   logic sck;
   logic si;
   logic so_drv;
   logic so_oe_n;
   // Released output reads as a pulled-up line
   wire  so_line = so_oe_n ? 1'b1 : so_drv;

   modport dev
   (
      input  cs_n,
      input  sck,
      input  si,
      output so_drv,
      output so_oe_n
   );

   modport host
   (
      output cs_n,
      output sck,
      output si,
      input  so_line
   );
endinterface : sfr_if

// ===== sfr_host.sv
module sfr_host
   import sfr_pkg::*;
#(
   parameter int HALF_CYC = sfr_pkg::SCK_HALF_CYC
)
(
   // Clock and reset
   input  wire logic                     ref_clk,
   input  wire logic                     nrst,
   // Serial link
   sfr_if.host                           lnk,
   // Command request
   input  wire logic                     start,
   input  wire logic [7:0]               opcode,
   input  wire logic [sfr_pkg::ADDR_W-1:0] addr,
   input  wire logic [15:0]              nbytes,
   input  wire logic                     spi_mode3,
   // Status and data
   output logic                          busy,
   output logic      [7:0]               rx_data,
   output logic                          rx_valid,
   output logic                          done
);
   import sfr_pkg::*;

   typedef struct packed
   {
      sfr_host_st_t       st;
      logic [7:0]         div;
      logic [CNT_W-1:0]   bitn;
      logic [CNT_W-1:0]   txb;
      logic [CNT_W-1:0]   total;
      logic [TX_W-1:0]    tx;
      logic [7:0]         rx;
      logic               cs_n;
      logic               sck;
      logic               si;
      logic               mode3;
      logic               rx_valid;
      logic               done;
   } sfr_host_state_t;

   sfr_host_state_t r_reg;
   sfr_host_state_t r_next;
   logic            tick;
   logic [7:0]      rx_sh;

   assign tick     = (r_reg.div == 8'(HALF_CYC - 1));
   assign rx_sh    = {r_reg.rx[6:0], lnk.so_line};
   assign busy     = (r_reg.st != H_IDLE);
   assign rx_data  = r_reg.rx;
   assign rx_valid = r_reg.rx_valid;
   assign done     = r_reg.done;
   assign lnk.cs_n = r_reg.cs_n;
   assign lnk.sck  = r_reg.sck;
   assign lnk.si   = r_reg.si;

   // Sequencer: each bit is a low half then a high half of the serial clock
   always_comb
   begin
      r_next          = r_reg;
      r_next.rx_valid = 1'b0;
      r_next.done     = 1'b0;
      r_next.div      = tick ? 8'h00 : r_reg.div + 8'h01;
      case (r_reg.st)
         H_IDLE:
         begin
            r_next.div = 8'h00;
            if (start)
            begin
               r_next.mode3 = spi_mode3;
               r_next.sck   = spi_mode3;
               r_next.tx    = {opcode, addr, 32'h0};
               r_next.txb   = CNT_W'(32) + CNT_W'(sfr_dummy_bits(opcode));
               r_next.total = CNT_W'(32) + CNT_W'(sfr_dummy_bits(opcode))
                            + CNT_W'({nbytes, 3'h0});
               r_next.bitn  = '0;
               r_next.st    = H_LEAD;
            end
         end
         H_LEAD:
         begin
            // Clock settles at its idle level before select falls, so mode switches
            // between frames never look like an edge inside a frame
            if (tick && r_reg.cs_n)
            begin
               r_next.cs_n = 1'b0;
            end
            else if (tick)
            begin
               r_next.sck = 1'b0;
               r_next.si  = r_reg.tx[TX_W-1];
               r_next.tx  = {r_reg.tx[TX_W-2:0], 1'b0};
               r_next.st  = H_LOW;
            end
         end
         H_LOW:
         begin
            if (tick)
            begin
               // Output sampled as the clock rises
               r_next.sck = 1'b1;
               r_next.st  = H_HIGH;
               if (r_reg.bitn >= r_reg.txb)
               begin
                  r_next.rx = rx_sh;
                  r_next.rx_valid = (r_reg.bitn[2:0] == 3'h7);
               end
            end
         end
         H_HIGH:
         begin
            if (tick)
            begin
               r_next.bitn = r_reg.bitn + CNT_W'(1);
               if (r_reg.bitn == r_reg.total - CNT_W'(1))
               begin
                  r_next.sck = r_reg.mode3;
                  r_next.st  = H_TRAIL;
               end
               else
               begin
                  r_next.sck = 1'b0;
                  r_next.si  = r_reg.tx[TX_W-1];
                  r_next.tx  = {r_reg.tx[TX_W-2:0], 1'b0};
                  r_next.st  = H_LOW;
               end
            end
         end
         H_TRAIL:
         begin
            // Select held low until the last wanted byte is in
            if (tick)
            begin
               r_next.cs_n = 1'b1;
               r_next.st   = H_GAP;
            end
         end
         H_GAP:
         begin
            if (tick)
            begin
               r_next.done = 1'b1;
               r_next.st   = H_IDLE;
            end
         end
         default:
         begin
            r_next.st = H_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         r_reg.st       <= H_IDLE;
         r_reg.div      <= 8'h00;
         r_reg.bitn     <= '0;
         r_reg.txb      <= '0;
         r_reg.total    <= '0;
         r_reg.tx       <= '0;
         r_reg.rx       <= 8'h00;
         r_reg.cs_n     <= 1'b1;
         r_reg.sck      <= 1'b0;
         r_reg.si       <= 1'b0;
         r_reg.mode3    <= 1'b0;
         r_reg.rx_valid <= 1'b0;
         r_reg.done     <= 1'b0;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

endmodule : sfr_host

// ===== sfr_link_sva.sv
module sfr_link_sva
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Link wires
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic so_drv,
   input wire logic so_oe_n
);
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct packed
   {
      logic       sck_prev;
      logic [7:0] rise_cnt;
   } sfr_chk_st_t;

   sfr_chk_st_t st_reg;
   sfr_chk_st_t st_next;

   // Seen clock rises in the frame, saturating so long reads never wrap
   always_comb
   begin
      st_next          = st_reg;
      st_next.sck_prev = sck;
      if (cs_n)
         st_next.rise_cnt = 8'h00;
      else if (sck && !st_reg.sck_prev && st_reg.rise_cnt != 8'hff)
         st_next.rise_cnt = st_reg.rise_cnt + 8'h01;
   end

   // Helper state register
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   release_on_deselect_a: assert property ($rose(cs_n) |-> ##[1:3] so_oe_n)
      else $error("output still driven after deselect");
   idle_released_a: assert property (cs_n [*3] |-> so_oe_n)
      else $error("output driven while not selected");
   out_hold_high_a: assert property (sck && $past(sck) && !so_oe_n && !$past(so_oe_n)
      |-> $stable(so_drv))
      else $error("output changed in clock high phase");
   drive_start_a: assert property ($fell(so_oe_n) |-> !$past(sck) && !cs_n)
      else $error("output enabled outside a clock low phase");
   drive_after_addr_a: assert property ($fell(so_oe_n) |-> st_reg.rise_cnt >= 8'h20)
      else $error("output enabled before opcode and address");
   sck_phase_a: assert property (!cs_n && $changed(sck) |=> $stable(sck))
      else $error("clock phase shorter than two cycles");
   si_hold_high_a: assert property (sck && $past(sck) && !cs_n && st_reg.rise_cnt != 8'h00
      |-> $stable(si))
      else $error("input changed while clock high");
   frame_min_a: assert property ($fell(cs_n) |-> !cs_n [*8])
      else $error("select released too early");
   quiet_start_a: assert property ($fell(cs_n) |-> $stable(sck) [*2])
      else $error("clock moved at select fall");
endmodule : sfr_link_sva

// ===== sfr_tb.sv
module testbench
   import sfr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic                ref_clk;
   logic                nrst;
   logic                page_size_bin;
   logic                start;
   logic                spi_mode3;
   logic [7:0]          opcode;
   logic [ADDR_W-1:0]   addr;
   logic [15:0]         nbytes;
   logic                busy;
   logic [7:0]          rx_data;
   logic                rx_valid;
   logic                done;
   logic [PAGE_W-1:0]   mem_page;
   logic [BYTE_W-1:0]   mem_byte;
   logic                mem_buf_sel;
   logic                mem_rd;
   logic [7:0]          mem_data;
   logic [7:0]          rxq[$];
   int                  bad_count;
   int                  tests_run;
   int                  rd_seen;

   // Storage contents; buffer and array patterns differ so a wrong source shows
   function automatic logic [7:0] mdata(input logic bsel, input logic [8:0] p,
                                        input logic [8:0] b);
      return bsel ? (b[7:0] ^ 8'h3c ^ {b[8], 7'h00}) : (p[7:0] + b[7:0] + {p[8], b[8], 6'h00});
   endfunction : mdata

   assign mem_data = mdata(mem_buf_sel, mem_page, mem_byte);

   sfr_if lnk_if ();

   sfr_dev sfr_dev_inst
   (
      .ref_clk(ref_clk), .nrst(nrst), .lnk(lnk_if.dev), .page_size_bin(page_size_bin),
      .mem_page(mem_page), .mem_byte(mem_byte), .mem_buf_sel(mem_buf_sel),
      .mem_rd(mem_rd), .mem_data(mem_data)
   );

   sfr_host #(.HALF_CYC(2)) sfr_host_inst
   (
      .ref_clk(ref_clk), .nrst(nrst), .lnk(lnk_if.host), .start(start), .opcode(opcode),
      .addr(addr), .nbytes(nbytes), .spi_mode3(spi_mode3), .busy(busy), .rx_data(rx_data),
      .rx_valid(rx_valid), .done(done)
   );

   sfr_link_sva sfr_link_sva_inst
   (
      .ref_clk(ref_clk), .nrst(nrst), .cs_n(lnk_if.cs_n), .sck(lnk_if.sck), .si(lnk_if.si),
      .so_drv(lnk_if.so_drv), .so_oe_n(lnk_if.so_oe_n)
   );

   // Clock, 100 ns period
   always #50 ref_clk = ~ref_clk;

   // Collect received bytes
   always @(posedge ref_clk)
   begin
      if (rx_valid === 1'b1)
         rxq.push_back(rx_data);
      if (mem_rd === 1'b1)
         rd_seen++;
   end

   task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_byte

   task automatic chk_cnt(input string what, input int exp, input int got);
      tests_run++;
      if (got != exp)
      begin
         bad_count++;
         $display("ERROR %s expected %0d seen %0d", what, exp, got);
      end
   endtask : chk_cnt

   // One read, then the stream is judged against the address walk
   task automatic rd_check(input logic [7:0] opc, input logic [23:0] ad, input int n,
                           input logic m3, input logic bin);
      logic [8:0] p;
      logic [8:0] b;
      logic [8:0] last;
      logic [7:0] got;
      bit         isbuf;
      bit         cont;
      bit         known;
      int         w;
      isbuf = (opc == OPC_BUF_FAST) || (opc == OPC_BUF_SLOW);
      cont  = (opc == OPC_CAR_LEGACY) || (opc == OPC_CAR_FAST) || (opc == OPC_CAR_SLOW);
      known = isbuf || cont || (opc == OPC_PAGE_READ);
      last  = bin ? LAST_BIN : LAST_WIDE;
      p     = bin ? ad[16:8] : ad[17:9];
      b     = bin ? {1'b0, ad[7:0]} : ad[8:0];
      rxq.delete();
      rd_seen = 0;
      page_size_bin <= bin;
      spi_mode3     <= m3;
      repeat (4) @(posedge ref_clk);
      start  <= 1'b1;
      opcode <= opc;
      addr   <= ad;
      nbytes <= n[15:0];
      @(posedge ref_clk);
      start <= 1'b0;
      w = 0;
      while (done !== 1'b1 && w < 20000)
      begin
         @(posedge ref_clk);
         w++;
      end
      chk_byte("done seen", 8'h01, {7'h00, done});
      repeat (4) @(posedge ref_clk);
      chk_byte("idle line", 8'h01, {7'h00, lnk_if.so_line});
      chk_byte("busy after done", 8'h00, {7'h00, busy});
      chk_cnt("byte count", n, rxq.size());
      // Mode 0 ends on a falling clock that prefetches one byte more
      chk_cnt("fetch count", known ? n + (m3 ? 0 : 1) : 0, rd_seen);
      for (int i = 0; i < n; i++)
      begin
         got = (i < rxq.size()) ? rxq[i] : 8'hxx;
         chk_byte("read byte", known ? mdata(isbuf, p, b) : 8'hff, got);
         if (b >= last)
         begin
            b = 9'h000;
            if (cont)
               p = p + 9'h001;
         end
         else
            b = b + 9'h001;
      end
   endtask : rd_check

   // Every read opcode once, clock mode alternating between mode 0 and mode 3
   task automatic t_opcodes();
      logic [7:0] ops [6];
      ops = '{OPC_CAR_LEGACY, OPC_CAR_FAST, OPC_CAR_SLOW, OPC_PAGE_READ, OPC_BUF_FAST,
              OPC_BUF_SLOW};
      for (int i = 0; i < 6; i++)
         rd_check(ops[i], {6'h00, 9'h003, 9'h00a}, 2, i[0], 1'b0);
   endtask : t_opcodes

   task automatic t_page_cross();
      rd_check(OPC_CAR_SLOW, {6'h00, 9'h005, 9'h106}, 4, 1'b0, 1'b0);
   endtask : t_page_cross

   task automatic t_array_wrap();
      rd_check(OPC_CAR_FAST, {7'h00, 9'h1ff, 8'hfe}, 4, 1'b1, 1'b1);
      rd_check(OPC_CAR_LEGACY, {6'h00, 9'h1ff, 9'h106}, 3, 1'b0, 1'b0);
   endtask : t_array_wrap

   task automatic t_page_wrap();
      rd_check(OPC_PAGE_READ, {7'h00, 9'h007, 8'hfe}, 4, 1'b1, 1'b1);
      rd_check(OPC_PAGE_READ, {6'h00, 9'h007, 9'h106}, 3, 1'b0, 1'b0);
   endtask : t_page_wrap

   // Ignored address bits all set
   task automatic t_buf_wrap();
      rd_check(OPC_BUF_FAST, {15'h7fff, 9'h106}, 4, 1'b0, 1'b0);
      rd_check(OPC_BUF_SLOW, {16'hffff, 8'hfe}, 3, 1'b1, 1'b1);
   endtask : t_buf_wrap

   task automatic t_unknown();
      rd_check(8'h55, 24'h000000, 2, 1'b0, 1'b0);
      rd_check(8'hd7, 24'h000000, 2, 1'b1, 1'b1);
   endtask : t_unknown

   task automatic stop_test();
      $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test

   // Watchdog sized well past the expected run length
   initial
   begin
      #(100 * 40000);
      bad_count++;
      $display("ERROR watchdog expected finish seen timeout");
      stop_test();
   end

   // Main sequence
   initial
   begin
      ref_clk       = 1'b0;
      nrst          = 1'b0;
      page_size_bin = 1'b0;
      start         = 1'b0;
      spi_mode3     = 1'b0;
      opcode        = 8'h00;
      addr          = '0;
      nbytes        = 16'h0000;
      bad_count     = 0;
      tests_run     = 0;
      rd_seen       = 0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      t_opcodes();
      t_page_cross();
      t_array_wrap();
      t_page_wrap();
      t_buf_wrap();
      t_unknown();
      t_page_cross();
      stop_test();
   end
endmodule : testbench
